// [shared/backlight_pkg.sv]
// Shared constants and types for the backlight dimming mode control.
package backlight_pkg;

   // Clock and timing.
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int LOCKOUT_TIME_NS = 100000;
   localparam int LOCKOUT_CYCLES = (LOCKOUT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SHUTDOWN_TIME_NS = 1000000;
   localparam int SHUTDOWN_CYCLES = (SHUTDOWN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int TIMER_BITS = 20;

   // End of sequence hold, in oscillator periods.
   localparam logic [8:0] EOS_PERIODS_DIVIDED = 9'h100;
   localparam logic [8:0] EOS_PERIODS_FULL = 9'h040;

   // Oscillator divider used when the divide select is high.
   localparam logic [1:0] DIVIDE_LAST = 2'h3;

   // Channels and levels in sixteenths of full scale.
   localparam int CHANNELS = 8;
   localparam logic [4:0] LEVEL_FULL = 5'h10;
   localparam logic [4:0] LEVEL_SOFT = 5'h01;

   // Analog duty measurement window.
   localparam int DUTY_WINDOW_LOG2 = 16;
   localparam int DUTY_BITS = 8;

   typedef enum logic [1:0] {MODE_SERIAL, MODE_ONOFF, MODE_ANALOG} dim_mode_t;
   typedef enum logic [1:0] {ST_OFF, ST_LOCKOUT, ST_SOFT, ST_RUN} power_state_t;

endpackage : backlight_pkg

// [hdl/sync_two_stage.sv]
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage #(
   parameter int WIDTH = 1
) (
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clockEnable,
   // Data.
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         syncOut <= '0;
      end else if (clockEnable) begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end

endmodule : sync_two_stage
`default_nettype wire

// [hdl/backlight_dimming_mode_control.sv]
// Mode selection, serial dimming, soft start and protection for the LED backlight driver.
`timescale 1ns/1ps
`default_nettype none
module backlight_dimming_mode_control #(
   parameter int LOCKOUT_CYCLES = backlight_pkg::LOCKOUT_CYCLES,
   parameter int SHUTDOWN_CYCLES = backlight_pkg::SHUTDOWN_CYCLES,
   parameter int DUTY_WINDOW_LOG2 = backlight_pkg::DUTY_WINDOW_LOG2
) (
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clockEnable,
   // Mode pins from the host.
   input wire logic enable,
   input wire logic pwm,
   input wire logic analog_pwm_input,
   // Configuration pins.
   input wire logic freq_divide_select,
   input wire logic string_count_select_0,
   input wire logic string_count_select_1,
   input wire logic string_count_select_2,
   // Analog comparator indications.
   input wire logic switchOver1A,
   input wire logic switchOver2A,
   input wire logic overTempHot,
   input wire logic overTempCooled,
   input wire logic ovpAboveSet,
   input wire logic ovpBelowClear,
   input wire logic [backlight_pkg::CHANNELS-1:0] channelAtRegulation,
   // Sink and boost controls.
   output logic [backlight_pkg::CHANNELS-1:0] led_sink_channel,
   output logic [backlight_pkg::CHANNELS-1:0] regulationMask,
   output logic [4:0] channel_current,
   output logic [backlight_pkg::DUTY_BITS-1:0] analogDuty,
   output logic analogMode,
   output logic boostSwitchOn,
   output logic overcurrent_limit,
   output logic softStart,
   output logic switchTick,
   // Status.
   output logic overvoltage_detect,
   output logic over_temperature_shutdown,
   output logic [3:0] pulseCount
);

   localparam int SYNC_W = 13 + backlight_pkg::CHANNELS;
   localparam int DB = backlight_pkg::DUTY_BITS;
   localparam int TB = backlight_pkg::TIMER_BITS;

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation.

   logic [SYNC_W-1:0] syncOut;
   logic enS, pwmS, apwmS, divS, over1S, over2S, hotS, coolS, ovpHiS, ovpLoS;
   logic [2:0] selS;
   logic [backlight_pkg::CHANNELS-1:0] atRegS;

   sync_two_stage #(.WIDTH(SYNC_W)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .clockEnable(clockEnable),
      .asyncIn({enable, pwm, analog_pwm_input, freq_divide_select, string_count_select_2,
                string_count_select_1, string_count_select_0, switchOver1A, switchOver2A,
                overTempHot, overTempCooled, ovpAboveSet, ovpBelowClear, channelAtRegulation}),
      .syncOut(syncOut)
   );

   assign {enS, pwmS, apwmS, divS, selS, over1S, over2S, hotS, coolS, ovpHiS, ovpLoS,
           atRegS} = syncOut;

   ////////////////////////////////////////////////////////////////////////////////
   // Channel selection.

   logic [backlight_pkg::CHANNELS-1:0] enabledMask;

   for (genvar i = 0; i < backlight_pkg::CHANNELS; i++) begin : g_mask
      assign enabledMask[i] = (3'(i) <= selS);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power state machine.

   backlight_pkg::power_state_t state_reg;
   backlight_pkg::dim_mode_t mode_reg;
   logic [TB-1:0] lockTimer_reg;
   logic [TB-1:0] idleTimer_reg;
   logic allLow, allRegulated, shutdownDue, lockoutDone;

   assign allLow = !enS && !pwmS && !apwmS;
   assign allRegulated = &(atRegS | ~enabledMask);
   assign shutdownDue = allLow && (idleTimer_reg == TB'(SHUTDOWN_CYCLES - 1));
   assign lockoutDone = (lockTimer_reg == TB'(LOCKOUT_CYCLES - 1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= backlight_pkg::ST_OFF;
         mode_reg <= backlight_pkg::MODE_SERIAL;
      end else if (clockEnable) begin
         case (state_reg)
            backlight_pkg::ST_OFF: begin
               // Mode chosen from the pin that woke the device.
               if (over_temperature_shutdown) begin
                  state_reg <= backlight_pkg::ST_OFF;
               end else if (enS && !apwmS) begin
                  mode_reg <= backlight_pkg::MODE_SERIAL;
                  state_reg <= backlight_pkg::ST_LOCKOUT;
               end else if (pwmS && !apwmS) begin
                  mode_reg <= backlight_pkg::MODE_ONOFF;
                  state_reg <= backlight_pkg::ST_SOFT;
               end else if (apwmS && !pwmS) begin
                  mode_reg <= backlight_pkg::MODE_ANALOG;
                  state_reg <= backlight_pkg::ST_LOCKOUT;
               end
            end
            backlight_pkg::ST_LOCKOUT: begin
               if (lockoutDone) begin
                  state_reg <= backlight_pkg::ST_SOFT;
               end
            end
            backlight_pkg::ST_SOFT: begin
               // Leave soft start once all enabled channels regulate.
               if (allRegulated) begin
                  state_reg <= backlight_pkg::ST_RUN;
               end
            end
            backlight_pkg::ST_RUN: begin
               state_reg <= backlight_pkg::ST_RUN;
            end
            default: begin
               state_reg <= backlight_pkg::ST_OFF;
            end
         endcase
         if (state_reg != backlight_pkg::ST_OFF) begin
            if (over_temperature_shutdown) begin
               state_reg <= backlight_pkg::ST_OFF;
            // Pwm low stops the on/off mode at once.
            end else if (mode_reg == backlight_pkg::MODE_ONOFF && !pwmS) begin
               state_reg <= backlight_pkg::ST_OFF;
            end else if (shutdownDue) begin
               state_reg <= backlight_pkg::ST_OFF;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lockTimer_reg <= '0;
      end else if (clockEnable) begin
         if (state_reg == backlight_pkg::ST_LOCKOUT) begin
            lockTimer_reg <= lockTimer_reg + TB'(1);
         end else begin
            lockTimer_reg <= '0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idleTimer_reg <= '0;
      end else if (clockEnable) begin
         if (allLow && state_reg != backlight_pkg::ST_OFF) begin
            idleTimer_reg <= idleTimer_reg + TB'(1);
         end else begin
            idleTimer_reg <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial pulse programming.

   logic enPrev_reg;
   logic [8:0] highCount_reg;
   logic [3:0] appliedCount_reg;
   logic serialLive, pulseRise, eosFire;
   logic [8:0] eosLimit;

   assign serialLive = mode_reg == backlight_pkg::MODE_SERIAL &&
                       (state_reg == backlight_pkg::ST_SOFT || state_reg == backlight_pkg::ST_RUN);
   assign pulseRise = enS && !enPrev_reg;
   // Hold threshold follows the divide select.
   assign eosLimit = divS ? backlight_pkg::EOS_PERIODS_DIVIDED : backlight_pkg::EOS_PERIODS_FULL;
   assign eosFire = serialLive && enS && (highCount_reg == eosLimit);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enPrev_reg <= 1'b0;
         highCount_reg <= '0;
      end else if (clockEnable) begin
         enPrev_reg <= enS;
         // High time counted, saturating one past the limit.
         if (!enS) begin
            highCount_reg <= '0;
         end else if (highCount_reg <= eosLimit) begin
            highCount_reg <= highCount_reg + 9'h001;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pulseCount <= '0;
         appliedCount_reg <= '0;
      end else if (clockEnable) begin
         // Count and level held at zero outside programming.
         if (!serialLive) begin
            pulseCount <= '0;
            appliedCount_reg <= '0;
         end else if (eosFire) begin
            appliedCount_reg <= pulseCount;
            pulseCount <= '0;
         // Four-bit counter wraps on the sixteenth pulse.
         end else if (pulseRise) begin
            pulseCount <= pulseCount + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Analog duty measurement.

   logic [DUTY_WINDOW_LOG2-1:0] window_reg;
   logic [DUTY_WINDOW_LOG2:0] highAccum_reg;

   // Duty of the analog input over a fixed window.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         window_reg <= '0;
         highAccum_reg <= '0;
         analogDuty <= '0;
      end else if (clockEnable) begin
         window_reg <= window_reg + DUTY_WINDOW_LOG2'(1);
         if (&window_reg) begin
            highAccum_reg <= '0;
            analogDuty <= highAccum_reg[DUTY_WINDOW_LOG2] ? {DB{1'b1}} :
                          highAccum_reg[DUTY_WINDOW_LOG2-1 -: DB];
         end else if (apwmS) begin
            highAccum_reg <= highAccum_reg + (DUTY_WINDOW_LOG2 + 1)'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Protection flags and open string tracking.

   logic ovpPrev_reg;
   logic [backlight_pkg::CHANNELS-1:0] openMask_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         over_temperature_shutdown <= 1'b0;
         overvoltage_detect <= 1'b0;
         ovpPrev_reg <= 1'b0;
      end else if (clockEnable) begin
         ovpPrev_reg <= overvoltage_detect;
         // Hot sets, cooled by the hysteresis clears.
         if (hotS) begin
            over_temperature_shutdown <= 1'b1;
         end else if (coolS) begin
            over_temperature_shutdown <= 1'b0;
         end
         if (ovpHiS) begin
            overvoltage_detect <= 1'b1;
         end else if (ovpLoS) begin
            overvoltage_detect <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         openMask_reg <= '0;
      end else if (clockEnable) begin
         if (state_reg == backlight_pkg::ST_OFF) begin
            openMask_reg <= '0;
         // Collapsed channels marked open; healthy ones restored.
         end else if (overvoltage_detect && !ovpPrev_reg) begin
            openMask_reg <= enabledMask & ~atRegS;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Boost switch and sink outputs.

   logic [1:0] divCount_reg;
   logic tickNow, powered, limitHit;

   // Switching tick divided by four on request.
   assign tickNow = divS ? (divCount_reg == backlight_pkg::DIVIDE_LAST) : 1'b1;
   assign powered = state_reg == backlight_pkg::ST_SOFT || state_reg == backlight_pkg::ST_RUN;
   assign limitHit = (state_reg == backlight_pkg::ST_SOFT) ? over1S : over2S;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divCount_reg <= '0;
         switchTick <= 1'b0;
         boostSwitchOn <= 1'b0;
      end else if (clockEnable) begin
         divCount_reg <= divCount_reg + 2'h1;
         switchTick <= tickNow;
         // Cycle by cycle current limit ends the on time.
         if (!powered || limitHit) begin
            boostSwitchOn <= 1'b0;
         end else if (tickNow) begin
            boostSwitchOn <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         led_sink_channel <= '0;
         regulationMask <= '0;
         channel_current <= backlight_pkg::LEVEL_FULL;
         overcurrent_limit <= 1'b0;
         softStart <= 1'b0;
         analogMode <= 1'b0;
      end else if (clockEnable) begin
         // Open channels keep their sink but leave the loop.
         led_sink_channel <= powered ? enabledMask : '0;
         regulationMask <= powered ? (enabledMask & ~openMask_reg) : '0;
         softStart <= state_reg == backlight_pkg::ST_SOFT;
         overcurrent_limit <= state_reg == backlight_pkg::ST_RUN;
         analogMode <= mode_reg == backlight_pkg::MODE_ANALOG;
         // Soft start level, then the programmed level.
         if (state_reg == backlight_pkg::ST_SOFT) begin
            channel_current <= backlight_pkg::LEVEL_SOFT;
         end else if (mode_reg == backlight_pkg::MODE_SERIAL) begin
            channel_current <= backlight_pkg::LEVEL_FULL - {1'b0, appliedCount_reg};
         end else begin
            channel_current <= backlight_pkg::LEVEL_FULL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n || !clockEnable);

   sequence s_wake;
      state_reg == backlight_pkg::ST_OFF ##1 state_reg == backlight_pkg::ST_LOCKOUT;
   endsequence

   sequence s_soft;
      state_reg == backlight_pkg::ST_SOFT ##1 clockEnable;
   endsequence

   a_wake_count_zero: assert property (s_wake |-> pulseCount == 4'h0)
      else $error("count not zero after wake");
   a_lockout_no_count: assert property (state_reg == backlight_pkg::ST_LOCKOUT |=>
      pulseCount == 4'h0)
      else $error("pulse counted during lockout");
   a_eos_applies_count: assert property (eosFire |=>
      appliedCount_reg == $past(pulseCount) && pulseCount == 4'h0)
      else $error("end of sequence did not apply count");
   a_soft_level_limit: assert property (s_soft |->
      channel_current == backlight_pkg::LEVEL_SOFT && !overcurrent_limit)
      else $error("soft start level or limit wrong");
   a_serial_level: assert property (state_reg == backlight_pkg::ST_RUN &&
      mode_reg == backlight_pkg::MODE_SERIAL |=>
      channel_current == 5'h10 - {1'b0, $past(appliedCount_reg)})
      else $error("serial level mismatch");
   a_onoff_stop: assert property (mode_reg == backlight_pkg::MODE_ONOFF && !pwmS &&
      state_reg != backlight_pkg::ST_OFF |=> state_reg == backlight_pkg::ST_OFF ##1
      led_sink_channel == '0)
      else $error("pwm low did not shut down");
   a_thermal_off: assert property (over_temperature_shutdown |=>
      state_reg == backlight_pkg::ST_OFF)
      else $error("running while over temperature");
   a_switch_limit: assert property (limitHit |=> !boostSwitchOn)
      else $error("switch stayed on past current limit");
   a_idle_shutdown: assert property (shutdownDue && state_reg != backlight_pkg::ST_OFF |=>
      state_reg == backlight_pkg::ST_OFF ##1 !boostSwitchOn)
      else $error("idle shutdown missed");
   a_channel_count: assert property ($countones(enabledMask) == int'(selS) + 1)
      else $error("wrong number of channels enabled");
   a_pulse_wrap: assert property (pulseRise && serialLive && !eosFire && pulseCount == 4'hf |=>
      pulseCount == 4'h0)
      else $error("counter did not wrap");

endmodule : backlight_dimming_mode_control
`default_nettype wire

// [tb/host_pins_model.sv]
// Host controller model that drives the three dimming mode pins.
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
   // Clock.
   input wire logic clock,
   // Mode pins.
   output logic enable,
   output logic pwm,
   output logic analog_pwm_input
);
   initial begin
      enable = 1'b0;
      pwm = 1'b0;
      analog_pwm_input = 1'b0;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask : idle
   task automatic setPins(input logic e, input logic p, input logic a);
      @(negedge clock);
      enable = e;
      pwm = p;
      analog_pwm_input = a;
   endtask : setPins
   task automatic pulses(input int n);
      repeat (n) begin
         enable = 1'b0;
         idle(4);
         enable = 1'b1;
         idle(4);
      end
   endtask : pulses
   task automatic analogBurst(input int hi, input int lo, input int reps);
      repeat (reps) begin
         analog_pwm_input = 1'b0;
         idle(lo);
         analog_pwm_input = 1'b1;
         idle(hi);
      end
   endtask : analogBurst
endmodule : host_pins_model
`default_nettype wire

// [tb/tb_backlight_dimming_mode_control.sv]
// Self-checking testbench for the backlight dimming mode control.
`timescale 1ns/1ps
`default_nettype none
module tb_backlight_dimming_mode_control;
   logic clock, rst_n, enable, pwm, analog_pwm_input, freqDivide, switchOver2A;
   logic clockEnable, switchOver1A;
   logic overTempHot, overTempCooled, ovpAboveSet, ovpBelowClear;
   logic analogMode, boostSwitchOn, overcurrent_limit, softStart, switchTick;
   logic overvoltage_detect, over_temperature_shutdown;
   logic [2:0] countSelect;
   logic [7:0] atReg, led_sink_channel, regulationMask, analogDuty;
   logic [4:0] channel_current;
   logic [3:0] pulseCount;
   int checked = 0;
   int miscompares = 0;
   ////////////////////////////////////////////////////////////////////////
   host_pins_model i_host_pins_model (.clock(clock), .enable(enable), .pwm(pwm),
      .analog_pwm_input(analog_pwm_input));
   backlight_dimming_mode_control #(.LOCKOUT_CYCLES(20), .SHUTDOWN_CYCLES(50),
      .DUTY_WINDOW_LOG2(9)) i_backlight_dimming_mode_control (
      .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .enable(enable), .pwm(pwm),
      .analog_pwm_input(analog_pwm_input), .freq_divide_select(freqDivide),
      .string_count_select_0(countSelect[0]), .string_count_select_1(countSelect[1]),
      .string_count_select_2(countSelect[2]), .switchOver1A(switchOver1A),
      .switchOver2A(switchOver2A), .overTempHot(overTempHot),
      .overTempCooled(overTempCooled), .ovpAboveSet(ovpAboveSet),
      .ovpBelowClear(ovpBelowClear), .channelAtRegulation(atReg),
      .led_sink_channel(led_sink_channel), .regulationMask(regulationMask),
      .channel_current(channel_current), .analogDuty(analogDuty), .analogMode(analogMode),
      .boostSwitchOn(boostSwitchOn), .overcurrent_limit(overcurrent_limit),
      .softStart(softStart), .switchTick(switchTick), .overvoltage_detect(overvoltage_detect),
      .over_temperature_shutdown(over_temperature_shutdown), .pulseCount(pulseCount));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b1;
      forever #5 clock = ~clock;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////
   task automatic testSerialStart;
      i_host_pins_model.setPins(1'b1, 1'b0, 1'b0);
      cyc(4);
      i_host_pins_model.pulses(2);
      chk({4'h0, pulseCount}, 8'h00);
      chk({3'h0, channel_current}, 8'h10);
      cyc(20);
      chk({7'h0, softStart}, 8'h01);
      chk({3'h0, channel_current}, 8'h01);
      chk({7'h0, overcurrent_limit}, 8'h00);
      chk(led_sink_channel, 8'h07);
      chk({7'h0, boostSwitchOn}, 8'h01);
      switchOver1A = 1'b1;
      cyc(4);
      chk({7'h0, boostSwitchOn}, 8'h00);
      atReg = 8'h07;
      cyc(6);
      chk({3'h0, channel_current}, 8'h10);
      chk({7'h0, overcurrent_limit}, 8'h01);
      chk({7'h0, boostSwitchOn}, 8'h01);
      switchOver1A = 1'b0;
      $display("serial start test done");
   endtask : testSerialStart
   task automatic testPulses;
      i_host_pins_model.pulses(12);
      cyc(50);
      chk({4'h0, pulseCount}, 8'h0c);
      chk({3'h0, channel_current}, 8'h10);
      cyc(25);
      chk({3'h0, channel_current}, 8'h04);
      chk({4'h0, pulseCount}, 8'h00);
      i_host_pins_model.pulses(17);
      cyc(50);
      chk({4'h0, pulseCount}, 8'h01);
      clockEnable = 1'b0;
      cyc(30);
      chk({4'h0, pulseCount}, 8'h01);
      chk({3'h0, channel_current}, 8'h04);
      clockEnable = 1'b1;
      cyc(25);
      chk({3'h0, channel_current}, 8'h0f);
      $display("pulse count test done");
   endtask : testPulses
   task automatic testBoost;
      logic [7:0] ticks;
      chk({7'h0, boostSwitchOn}, 8'h01);
      switchOver2A = 1'b1;
      cyc(4);
      chk({7'h0, boostSwitchOn}, 8'h00);
      cyc(3);
      chk({7'h0, boostSwitchOn}, 8'h00);
      switchOver2A = 1'b0;
      freqDivide = 1'b1;
      cyc(6);
      ticks = 8'h00;
      repeat (40) begin
         @(negedge clock);
         ticks = ticks + {7'h0, switchTick};
      end
      chk(ticks, 8'h0a);
      $display("boost test done");
   endtask : testBoost
   task automatic testOpenString;
      atReg = 8'h05;
      ovpAboveSet = 1'b1;
      cyc(5);
      chk({7'h0, overvoltage_detect}, 8'h01);
      chk(regulationMask, 8'h05);
      chk(led_sink_channel, 8'h07);
      ovpAboveSet = 1'b0;
      cyc(5);
      chk({7'h0, overvoltage_detect}, 8'h01);
      ovpBelowClear = 1'b1;
      cyc(5);
      chk({7'h0, overvoltage_detect}, 8'h00);
      ovpBelowClear = 1'b0;
      atReg = 8'h07;
      ovpAboveSet = 1'b1;
      cyc(5);
      chk(regulationMask, 8'h07);
      ovpAboveSet = 1'b0;
      $display("open string test done");
   endtask : testOpenString
   task automatic testShutdown;
      i_host_pins_model.setPins(1'b0, 1'b0, 1'b0);
      cyc(40);
      chk(led_sink_channel, 8'h07);
      cyc(20);
      chk(led_sink_channel, 8'h00);
      chk({7'h0, boostSwitchOn}, 8'h00);
      $display("shutdown test done");
   endtask : testShutdown
   task automatic testOnOff;
      countSelect = 3'h7;
      atReg = 8'h00;
      i_host_pins_model.setPins(1'b0, 1'b1, 1'b0);
      cyc(6);
      chk(led_sink_channel, 8'hff);
      atReg = 8'hff;
      cyc(6);
      chk({3'h0, channel_current}, 8'h10);
      i_host_pins_model.setPins(1'b0, 1'b0, 1'b0);
      cyc(5);
      chk(led_sink_channel, 8'h00);
      $display("on off test done");
   endtask : testOnOff
   task automatic testAnalog;
      countSelect = 3'h5;
      atReg = 8'h00;
      i_host_pins_model.setPins(1'b0, 1'b0, 1'b1);
      cyc(30);
      chk({6'h0, softStart, analogMode}, 8'h03);
      chk(led_sink_channel, 8'h3f);
      atReg = 8'h3f;
      i_host_pins_model.analogBurst(6, 2, 200);
      chk({7'h0, analogDuty >= 8'hbd && analogDuty <= 8'hc2}, 8'h01);
      overTempHot = 1'b1;
      cyc(5);
      chk({7'h0, over_temperature_shutdown}, 8'h01);
      chk(led_sink_channel, 8'h00);
      overTempHot = 1'b0;
      overTempCooled = 1'b1;
      cyc(5);
      chk({7'h0, over_temperature_shutdown}, 8'h00);
      $display("analog and thermal test done");
   endtask : testAnalog
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      clockEnable = 1'b1;
      switchOver1A = 1'b0;
      freqDivide = 1'b0;
      countSelect = 3'h2;
      switchOver2A = 1'b0;
      overTempHot = 1'b0;
      overTempCooled = 1'b0;
      ovpAboveSet = 1'b0;
      ovpBelowClear = 1'b0;
      atReg = 8'h00;
      cyc(3);
      chk({3'h0, channel_current}, 8'h10);
      chk(led_sink_channel, 8'h00);
      rst_n = 1'b1;
      testSerialStart();
      testPulses();
      testBoost();
      testOpenString();
      testShutdown();
      testOnOff();
      testAnalog();
      summarize();
   end
   initial begin
      repeat (10000) @(posedge clock);
      miscompares++;
      $display("watchdog expired");
      summarize();
   end
endmodule : tb_backlight_dimming_mode_control
`default_nettype wire
